// ### hw/blk_consts.svh
// Offsets, command codes, field positions, reset values and timing counts
`ifndef BLK_CONSTS_SVH
`define BLK_CONSTS_SVH
// ----------------------------------------------------------------
// Register offsets of the controller
// ----------------------------------------------------------------
`define BLK_OFF_CTRL 12'h000
`define BLK_OFF_CMD 12'h004
`define BLK_OFF_ADDR 12'h008
`define BLK_OFF_WDATA 12'h00c
`define BLK_OFF_STATUS 12'h010
`define BLK_OFF_RDATA 12'h014
`define BLK_OFF_LOCK 12'h018
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define BLK_CTRL_WP 0
`define BLK_ST_BUSY 8
`define BLK_ST_DONE 9
`define BLK_CTRL_RESET 1'b0
`define BLK_LOCK_RESET 2'b01
`define BLK_AW 22
`define BLK_IDX_LSB 15
`define BLK_ID_LOCK_OFS 22'h000002
// ----------------------------------------------------------------
// Flash command codes
// ----------------------------------------------------------------
`define BLK_C_LOCK_SETUP 8'h60
`define BLK_C_LOCK_CONF 8'h01
`define BLK_C_UNLOCK_CONF 8'hd0
`define BLK_C_LDOWN_CONF 8'h2f
`define BLK_C_READ_ID 8'h90
`define BLK_C_READ_ARRAY 8'hff
`define BLK_C_READ_STATUS 8'h70
`define BLK_C_CLEAR_STATUS 8'h50
`define BLK_C_PROG_SETUP 8'h40
`define BLK_C_ERASE_SETUP 8'h20
`define BLK_C_ERASE_CONF 8'hd0
`define BLK_C_SUSPEND 8'hb0
`define BLK_C_RESUME 8'hd0
// ----------------------------------------------------------------
// Status byte bit positions
// ----------------------------------------------------------------
`define BLK_SR_READY 7
`define BLK_SR_ESUSP 6
`define BLK_SR_ERASE 5
`define BLK_SR_PROG 4
`define BLK_SR_VPP 3
`define BLK_SR_PSUSP 2
`define BLK_SR_LOCK 1
`define BLK_SR_RSVD 0
// ----------------------------------------------------------------
// Bus cycle and reset pulse timing in pclk cycles
// ----------------------------------------------------------------
`define BLK_SETUP_CYC 4'd2
`define BLK_PULSE_CYC 4'd4
`define BLK_RST_CYC 4'd8
`endif

// ### hw/blk_ctrl.sv
// Host controller for flash block locking and status, with APB registers
//
// Notes on behaviour
// - Lock is setup code then lock confirm.
// - Unlock is setup code then unlock confirm.
// - Lock-down is setup code then lock-down confirm.
// - Read-identifier, base plus two gives bits.
`timescale 1ns/1ps
`include "blk_consts.svh"
module blk_ctrl #(
  parameter int IW = `BLK_AW - `BLK_IDX_LSB
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash pins
  output blk_pkg::blk_fpin_t fpin,
  input wire logic [15:0] f_dq_i,
  output logic f_wp_n,
  output logic f_rst_n
);
  import blk_pkg::*;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_C1 = 3'b001,
    M_C2 = 3'b010,
    M_POLL = 3'b011,
    M_RDID = 3'b100,
    M_CLR = 3'b101,
    M_ARR = 3'b110,
    M_RST = 3'b111
  } blk_mst_t;

  blk_mst_t st_q;
  blk_op_t op_q;
  logic wp_q;
  logic [`BLK_AW-1:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic [7:0] sr_q;
  logic done_q;
  logic pend_q;
  logic [3:0] rcnt_q;
  logic breq_v;
  blk_breq_t breq;
  logic ack;
  logic [15:0] bus_rd;
  logic [1:0] lk_cur;
  logic mem_we;
  logic [1:0] mem_wd;
  logic mem_clr;
  logic wr_acc;
  logic rd_acc;
  logic cmd_go;
  blk_flags_t flags;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] first_code(input blk_op_t op);
    unique case (op)
      OP_LOCK, OP_UNLOCK, OP_LDOWN: first_code = `BLK_C_LOCK_SETUP;
      OP_RDLOCK: first_code = `BLK_C_READ_ID;
      OP_RDSTAT: first_code = `BLK_C_READ_STATUS;
      OP_PROG: first_code = `BLK_C_PROG_SETUP;
      OP_ERASE: first_code = `BLK_C_ERASE_SETUP;
      OP_SUSP: first_code = `BLK_C_SUSPEND;
      OP_RESUME: first_code = `BLK_C_RESUME;
      default: first_code = `BLK_C_READ_ARRAY;
    endcase
  endfunction : first_code

  // Predicted lock bits after a completed lock command
  function automatic logic [1:0] next_lock(input logic [1:0] cur,
                                           input blk_op_t op,
                                           input logic wp_high);
    logic [1:0] n;
    n = cur;
    if (!(cur[1] && !wp_high)) begin
      unique case (op)
        OP_LOCK: n[0] = 1'b1;
        OP_UNLOCK: n[0] = 1'b0;
        OP_LDOWN: n = 2'b11;
        default: n = cur;
      endcase
    end
    next_lock = n;
  endfunction : next_lock

  // ----------------------------------------------------------------
  // APB register access
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign cmd_go = wr_acc && (paddr == `BLK_OFF_CMD) && (st_q == M_IDLE);
  // Reserved bit 0 is kept out of sr_q and flags, but RDATA keeps the raw status read
  assign flags = blk_decode(sr_q);

  always_comb begin
    pslverr = 1'b0;
    unique case (paddr)
      `BLK_OFF_CTRL, `BLK_OFF_CMD, `BLK_OFF_ADDR, `BLK_OFF_WDATA,
      `BLK_OFF_STATUS, `BLK_OFF_RDATA, `BLK_OFF_LOCK: pslverr = 1'b0;
      default: pslverr = psel && penable;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `BLK_OFF_CTRL: prdata <= {31'h0, wp_q};
        `BLK_OFF_CMD: prdata <= {28'h0, op_q};
        `BLK_OFF_ADDR: prdata <= {{(32-`BLK_AW){1'b0}}, addr_q};
        `BLK_OFF_WDATA: prdata <= {16'h0, wdata_q};
        `BLK_OFF_STATUS: prdata <= {9'h0, flags, 6'h0, done_q,
                                    st_q != M_IDLE, sr_q};
        `BLK_OFF_RDATA: prdata <= {16'h0, rdata_q};
        `BLK_OFF_LOCK: prdata <= {29'h0, ~wp_q, lk_cur};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Operands are frozen while an operation runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= `BLK_CTRL_RESET;
      addr_q <= '0;
      wdata_q <= 16'h0000;
      op_q <= OP_LOCK;
    end else if (wr_acc && st_q == M_IDLE) begin
      unique case (paddr)
        `BLK_OFF_CTRL: wp_q <= pwdata[`BLK_CTRL_WP];
        `BLK_OFF_ADDR: addr_q <= pwdata[`BLK_AW-1:0];
        `BLK_OFF_WDATA: wdata_q <= pwdata[15:0];
        `BLK_OFF_CMD: op_q <= blk_op_t'(pwdata[3:0]);
        default: ;
      endcase
    end
  end

  // Done is sticky; a completion in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) done_q <= 1'b0;
    else if ((st_q == M_ARR && ack) || (st_q == M_RST && rcnt_q == 4'h1) ||
             (st_q == M_POLL && ack && op_q == OP_RDSTAT) ||
             (st_q == M_C1 && ack && op_q == OP_RESUME))
      done_q <= 1'b1;
    else if (wr_acc && paddr == `BLK_OFF_STATUS && pwdata[`BLK_ST_DONE])
      done_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Pins driven directly
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f_wp_n <= 1'b0;
      f_rst_n <= 1'b0;
    end else begin
      f_wp_n <= wp_q;
      f_rst_n <= !(st_q == M_RST);
    end
  end

  // ----------------------------------------------------------------
  // Bus request for the current step
  // ----------------------------------------------------------------
  always_comb begin
    breq.wr = 1'b1;
    breq.addr = addr_q;
    breq.data = {8'h00, `BLK_C_READ_ARRAY};
    unique case (st_q)
      M_C1: breq.data = {8'h00, first_code(op_q)};
      M_C2: begin
        unique case (op_q)
          OP_LOCK: breq.data = {8'h00, `BLK_C_LOCK_CONF};
          OP_UNLOCK: breq.data = {8'h00, `BLK_C_UNLOCK_CONF};
          OP_LDOWN: breq.data = {8'h00, `BLK_C_LDOWN_CONF};
          OP_ERASE: breq.data = {8'h00, `BLK_C_ERASE_CONF};
          default: breq.data = wdata_q;
        endcase
      end
      M_POLL: breq.wr = 1'b0;
      M_RDID: begin
        breq.wr = 1'b0;
        breq.addr = addr_q + `BLK_ID_LOCK_OFS;
      end
      M_CLR: breq.data = {8'h00, `BLK_C_CLEAR_STATUS};
      default: breq.data = {8'h00, `BLK_C_READ_ARRAY};
    endcase
  end

  assign breq_v = !pend_q && st_q != M_IDLE && st_q != M_RST;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pend_q <= 1'b0;
    else if (ack) pend_q <= 1'b0;
    else if (breq_v) pend_q <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= M_IDLE;
      rcnt_q <= 4'h0;
    end else begin
      unique case (st_q)
        M_IDLE: begin
          if (cmd_go) begin
            if (pwdata[3:0] == OP_RESET) begin
              st_q <= M_RST;
              rcnt_q <= `BLK_RST_CYC;
            end else begin
              st_q <= M_C1;
            end
          end
        end
        M_C1: if (ack) begin
          unique case (op_q)
            OP_RDLOCK: st_q <= M_RDID;
            OP_RDSTAT, OP_SUSP: st_q <= M_POLL;
            OP_RESUME: st_q <= M_IDLE;
            default: st_q <= M_C2;
          endcase
        end
        M_C2: if (ack) st_q <= M_POLL;
        M_POLL: if (ack) begin
          if (op_q == OP_RDSTAT) st_q <= M_IDLE;
          else if (bus_rd[`BLK_SR_READY]) begin
            // Error flags stay in the device until cleared, so clear them
            if (bus_rd[`BLK_SR_ERASE] || bus_rd[`BLK_SR_PROG] ||
                bus_rd[`BLK_SR_VPP] || bus_rd[`BLK_SR_LOCK])
              st_q <= M_CLR;
            else st_q <= M_ARR;
          end
        end
        M_RDID: if (ack) st_q <= M_ARR;
        M_CLR: if (ack) st_q <= M_ARR;
        M_ARR: if (ack) st_q <= M_IDLE;
        M_RST: begin
          rcnt_q <= rcnt_q - 4'h1;
          if (rcnt_q == 4'h1) st_q <= M_IDLE;
        end
      endcase
    end
  end

  // Status and read data capture; bit 0 masked as it is undefined
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_q <= 8'h00;
      rdata_q <= 16'h0000;
    end else if (ack && !breq.wr) begin
      rdata_q <= bus_rd;
      if (st_q == M_POLL && (bus_rd[`BLK_SR_READY] || op_q == OP_RDSTAT))
        sr_q <= bus_rd[7:0] & 8'hfe;
    end
  end

  // ----------------------------------------------------------------
  // Shadow of block lock bits
  // ----------------------------------------------------------------
  always_comb begin
    mem_clr = st_q == M_RST;
    mem_we = 1'b0;
    mem_wd = lk_cur;
    if (st_q == M_RDID && ack) begin
      mem_we = 1'b1;
      mem_wd = bus_rd[1:0];
    end else if (st_q == M_POLL && ack && bus_rd[`BLK_SR_READY] &&
                 !bus_rd[`BLK_SR_PROG] && !bus_rd[`BLK_SR_ERASE] &&
                 (op_q == OP_LOCK || op_q == OP_UNLOCK ||
                  op_q == OP_LDOWN)) begin
      mem_we = 1'b1;
      mem_wd = next_lock(lk_cur, op_q, wp_q);
    end
  end

  blk_lockmem #(.IW(IW)) u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .clr(mem_clr),
    .we(mem_we),
    .waddr(addr_q[`BLK_AW-1:`BLK_IDX_LSB]),
    .wdata(mem_wd),
    .raddr(addr_q[`BLK_AW-1:`BLK_IDX_LSB]),
    .rdata(lk_cur)
  );

  blk_fbus u_bus (
    .pclk(pclk),
    .presetn(presetn),
    .req(breq_v),
    .breq(breq),
    .ack(ack),
    .rdata(bus_rd),
    .fpin(fpin),
    .f_dq_i(f_dq_i)
  );
endmodule : blk_ctrl

// ### hw/blk_fbus.sv
// One asynchronous flash bus cycle: write strobe or read with sampling
`timescale 1ns/1ps
`include "blk_consts.svh"
module blk_fbus (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request side
  input wire logic req,
  input blk_pkg::blk_breq_t breq,
  output logic ack,
  output logic [15:0] rdata,
  // Flash pins
  output blk_pkg::blk_fpin_t fpin,
  input wire logic [15:0] f_dq_i
);
  import blk_pkg::*;
  typedef enum logic [1:0] {
    F_IDLE = 2'b00,
    F_SET = 2'b01,
    F_PULSE = 2'b10,
    F_SAMP = 2'b11
  } blk_fst_t;

  blk_fst_t st_q;
  logic [3:0] cnt_q;
  logic [15:0] s1_q, s2_q, s3_q;

  // ----------------------------------------------------------------
  // Data bus synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 16'h0000;
      s2_q <= 16'h0000;
      s3_q <= 16'h0000;
    end else begin
      s1_q <= f_dq_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= F_IDLE;
      cnt_q <= 4'h0;
      ack <= 1'b0;
      rdata <= 16'h0000;
      fpin <= '{addr: '0, dq_o: 16'h0000, dq_oe: 1'b0,
                ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    end else begin
      ack <= 1'b0;
      unique case (st_q)
        F_IDLE: begin
          fpin.ce_n <= 1'b1;
          fpin.oe_n <= 1'b1;
          fpin.we_n <= 1'b1;
          fpin.dq_oe <= 1'b0;
          if (req) begin
            fpin.addr <= breq.addr;
            fpin.dq_o <= breq.data;
            fpin.dq_oe <= breq.wr;
            fpin.ce_n <= 1'b0;
            cnt_q <= `BLK_SETUP_CYC;
            st_q <= F_SET;
          end
        end
        F_SET: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1) begin
            fpin.we_n <= ~fpin.dq_oe;
            fpin.oe_n <= fpin.dq_oe;
            cnt_q <= `BLK_PULSE_CYC;
            st_q <= F_PULSE;
          end
        end
        F_PULSE: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1) begin
            if (fpin.dq_oe) begin
              // Data stays driven through the rising strobe for hold
              fpin.we_n <= 1'b1;
              ack <= 1'b1;
              st_q <= F_IDLE;
            end else begin
              st_q <= F_SAMP;
            end
          end
        end
        F_SAMP: begin
          // Wait until the last two sync stages agree on the word
          if (s2_q == s3_q) begin
            rdata <= s3_q;
            fpin.oe_n <= 1'b1;
            ack <= 1'b1;
            st_q <= F_IDLE;
          end
        end
      endcase
    end
  end
endmodule : blk_fbus

// ### hw/blk_lockmem.sv
// Shadow memory of the per-block lock and lock-down bits
`timescale 1ns/1ps
`include "blk_consts.svh"
module blk_lockmem #(
  parameter int IW = 7
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic clr,
  input wire logic we,
  input wire logic [IW-1:0] waddr,
  input wire logic [1:0] wdata,
  // Read port
  input wire logic [IW-1:0] raddr,
  output logic [1:0] rdata
);
  import blk_pkg::*;
  logic [1:0] mem_q [2**IW];

  // A clear covers every entry at once, matching a device reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2**IW; i++) mem_q[i] <= `BLK_LOCK_RESET;
    end else if (clr) begin
      for (int i = 0; i < 2**IW; i++) mem_q[i] <= `BLK_LOCK_RESET;
    end else if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rdata <= `BLK_LOCK_RESET;
    else rdata <= mem_q[raddr];
  end
endmodule : blk_lockmem

// ### hw/blk_pkg.sv
// Types and decode helpers shared by the block lock controller
package blk_pkg;
`include "blk_consts.svh"
  typedef enum logic [3:0] {
    OP_LOCK = 4'h0,
    OP_UNLOCK = 4'h1,
    OP_LDOWN = 4'h2,
    OP_RDLOCK = 4'h3,
    OP_RDSTAT = 4'h4,
    OP_PROG = 4'h5,
    OP_ERASE = 4'h6,
    OP_SUSP = 4'h7,
    OP_RESUME = 4'h8,
    OP_RESET = 4'h9
  } blk_op_t;

  typedef struct packed {
    logic wr;
    logic [`BLK_AW-1:0] addr;
    logic [15:0] data;
  } blk_breq_t;

  typedef struct packed {
    logic [`BLK_AW-1:0] addr;
    logic [15:0] dq_o;
    logic dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } blk_fpin_t;

  typedef struct packed {
    logic esusp;
    logic psusp;
    logic erase_err;
    logic prog_err;
    logic seq_err;
    logic lock_viol;
    logic vpp_low;
  } blk_flags_t;

  function automatic blk_flags_t blk_decode(input logic [7:0] sr);
    blk_flags_t f;
    f.esusp = sr[`BLK_SR_ESUSP];
    f.psusp = sr[`BLK_SR_PSUSP];
    f.erase_err = sr[`BLK_SR_ERASE];
    f.prog_err = sr[`BLK_SR_PROG];
    f.seq_err = sr[`BLK_SR_ERASE] & sr[`BLK_SR_PROG] & sr[`BLK_SR_READY];
    f.lock_viol = sr[`BLK_SR_LOCK];
    f.vpp_low = sr[`BLK_SR_VPP];
    return f;
  endfunction : blk_decode
endpackage : blk_pkg

// ### testbench/blk_ctrl_checker.sv
// Checker for the flash pins and APB port of the lock controller
`timescale 1ns/1ps
module blk_ctrl_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Flash pins
  input blk_pkg::blk_fpin_t fpin,
  input wire logic [15:0] f_dq_i,
  input wire logic f_wp_n,
  input wire logic f_rst_n
);
  import blk_pkg::*;
  logic [7:0] prev_q;
  logic [21:0] prev_addr_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Last command byte written, for pairing checks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 8'h00;
      prev_addr_q <= '0;
    end else if (!fpin.we_n) begin
      prev_q <= fpin.dq_o[7:0];
      prev_addr_q <= fpin.addr;
    end
  end
  pslverr_phase_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  we_width_a: assert property ($fell(fpin.we_n) |->
    (!fpin.we_n) [*4] ##1 fpin.we_n) else $error("write strobe width");
  wr_drive_a: assert property (!fpin.we_n |->
    fpin.dq_oe && !fpin.ce_n && fpin.oe_n) else $error("write cycle pins");
  rd_release_a: assert property (!fpin.oe_n |->
    !fpin.dq_oe && fpin.we_n && !fpin.ce_n) else $error("read cycle pins");
  wr_hold_a: assert property (!fpin.we_n && !$past(fpin.we_n) |->
    $stable(fpin.addr) && $stable(fpin.dq_o)) else $error("write hold");
  setup_pair_a:
    assert property ($fell(fpin.we_n) && prev_q == 8'h60 |->
      fpin.dq_o[7:0] inside {8'h01, 8'hd0, 8'h2f} &&
      fpin.addr == prev_addr_q) else $error("bad confirm after setup");
  confirm_seq_a:
    assert property ($fell(fpin.we_n) && fpin.dq_o[7:0] inside
      {8'h01, 8'h2f} |-> prev_q == 8'h60) else $error("confirm alone");
  id_read_a:
    assert property ($fell(fpin.oe_n) && prev_q == 8'h90 |->
      fpin.addr[14:0] == 15'h2 && fpin.addr[21:15] == prev_addr_q[21:15])
      else $error("lock read address");
  status_mask_a:
    assert property (psel && penable && !pwrite && paddr == 12'h010 |->
      prdata[0] == 1'b0) else $error("reserved status bit");
  cover property ($fell(fpin.we_n) && fpin.dq_o[7:0] == 8'h2f);
  cover property ($fell(fpin.oe_n) && prev_q == 8'h90);
  cover property (pslverr);
endmodule : blk_ctrl_checker
bind blk_ctrl blk_ctrl_checker u_blk_ctrl_checker (.pclk, .presetn, .paddr,
  .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .fpin,
  .f_dq_i, .f_wp_n, .f_rst_n);

// ### testbench/blk_ctrl_tb.sv
// Self-checking bench for the block lock controller
`timescale 1ns/1ps
module blk_ctrl_tb;
  import blk_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, f_wp_n, f_rst_n;
  logic vpp_low = 1'b0;
  blk_fpin_t fpin;
  logic [15:0] f_dq_i;
  int num_errors = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h79ee;
  int lk[128], ld[128];
  int wp = 0;
  logic [7:0] sr;
  blk_op_t ops[5] = '{OP_LOCK, OP_UNLOCK, OP_LDOWN, OP_PROG, OP_ERASE};
  logic [6:0] blks[4] = '{7'd0, 7'd1, 7'd63, 7'd127};
  always #12.5 pclk = ~pclk;
  blk_ctrl u_blk_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fpin(fpin),
    .f_dq_i(f_dq_i), .f_wp_n(f_wp_n), .f_rst_n(f_rst_n));
  blk_flash_model u_blk_flash_model (.fpin(fpin), .f_dq_i(f_dq_i),
    .f_wp_n(f_wp_n), .f_rst_n(f_rst_n), .vpp_low(vpp_low));
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Data low byte is fixed so it never looks like a command code
  task automatic run_op(input blk_op_t op, input logic [6:0] b,
                        output logic [31:0] r);
    logic e;
    apb(1'b1, 12'h008, {10'h0, b, 15'h0}, r, e);
    apb(1'b1, 12'h00c, {16'h0, seed[15:8], 8'h3c}, r, e);
    apb(1'b1, 12'h004, {28'h0, op}, r, e);
    r = 32'h100;
    while (r[8] !== 1'b0) apb(1'b0, 12'h010, 32'h0, r, e);
  endtask : run_op
  task automatic step(input blk_op_t op, input logic [6:0] b);
    logic [31:0] r;
    logic e;
    int i;
    logic [6:0] ex;
    i = b;
    run_op(op, b, r);
    case (op)
      OP_LOCK: lk[i] = 1;
      OP_UNLOCK: if (!(ld[i] && !wp)) lk[i] = 0;
      OP_LDOWN: begin
        lk[i] = 1;
        ld[i] = 1;
      end
      OP_RESET: foreach (lk[j]) begin
        lk[j] = 1;
        ld[j] = 0;
      end
      default: ;
    endcase
    sr = (op == OP_SUSP) ? 8'h84 : 8'h80;
    if (op == OP_PROG || op == OP_ERASE)
      sr = lk[i] ? 8'h82 : vpp_low ? 8'h88 : i != 2 ? 8'h80 :
           (op == OP_PROG) ? 8'h90 : 8'ha0;
    // Decoded flags sit at bits 22:16 of the status word
    ex = {sr[6], sr[2], sr[5:4], sr[5] & sr[4] & sr[7], sr[1], sr[3]};
    if (!(op inside {OP_RDLOCK, OP_RESET, OP_RESUME})) begin
      chk("status", {sr[7:1], 1'b0}, r[7:0]);
      chk("flags", ex, r[22:16]);
    end
    run_op(OP_RDLOCK, b, r);
    apb(1'b0, 12'h018, 32'h0, r, e);
    chk("lock", {~wp[0], ld[i][0], lk[i][0]}, r[2:0]);
  endtask : step
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  // ----
  // Main sequence
  // ----
  initial begin
    logic [31:0] r;
    logic e;
    foreach (lk[j]) begin
      lk[j] = 1;
      ld[j] = 0;
    end
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk("ctrl", 32'h0, r);
    for (int k = 0; k < 4; k++) step(OP_RDLOCK, blks[k]);
    apb(1'b0, 12'h0f0, 32'h0, r, e);
    chk("slverr", 32'h1, {31'h0, e});
    chk("unmapped", 32'h0, r);
    $display("test reset_and_map done");
    for (int k = 0; k < 60; k++) begin
      seed = xorshift(seed);
      vpp_low <= (seed[20:18] == 3'd0);
      if (seed[9:8] == 2'd0) begin
        apb(1'b1, 12'h000, {31'h0, seed[10]}, r, e);
        if (wp && !seed[10]) foreach (lk[j]) if (ld[j]) lk[j] = 1;
        wp = seed[10];
      end
      step(ops[seed[2:0] % 5], blks[seed[4:3]]);
    end
    $display("test random_locking done");
    vpp_low <= 1'b1;
    step(OP_UNLOCK, 7'd6);
    step(OP_PROG, 7'd6);
    vpp_low <= 1'b0;
    step(OP_UNLOCK, 7'd2);
    step(OP_PROG, 7'd2);
    step(OP_ERASE, 7'd2);
    step(OP_SUSP, 7'd6);
    step(OP_RESUME, 7'd6);
    step(OP_RDSTAT, 7'd6);
    $display("test vpp_and_suspend done");
    step(OP_LDOWN, 7'd5);
    step(OP_RESET, 7'd5);
    $display("test flash_reset done");
    end_sim();
  end
  initial begin
    #2000000;
    num_errors++;
    end_sim();
  end
endmodule : blk_ctrl_tb

// ### testbench/blk_flash_model.sv
// Behavioural flash device: command decoder, lock bits and status byte
`timescale 1ns/1ps
module blk_flash_model (
  // Flash pins
  input blk_pkg::blk_fpin_t fpin,
  output logic [15:0] f_dq_i,
  input wire logic f_wp_n,
  input wire logic f_rst_n,
  // Fault control
  input wire logic vpp_low
);
  import blk_pkg::*;
  logic [1:0] lb [128];
  logic [7:0] sr;
  logic [7:0] pend;
  logic [1:0] mode;
  logic [15:0] rd;
  logic [15:0] last = 16'h5a5a;
  logic wp_q;
  logic rsv = 1'b0;
  int busy = 0;
  wire [6:0] bi = fpin.addr[21:15];
  // ----
  // Command decode on the write strobe
  // ----
  always @(posedge fpin.we_n or negedge f_rst_n or negedge f_wp_n) begin
    if (!f_rst_n) begin
      foreach (lb[i]) lb[i] = 2'b01;
      sr = 8'h80;
      pend = 8'h00;
      mode = 2'd0;
      busy = 0;
    end else if (wp_q && !f_wp_n) begin
      foreach (lb[i]) if (lb[i][1]) lb[i][0] = 1'b1;
    end else if (pend == 8'h60) begin
      pend = 8'h00;
      mode = 2'd1;
      case (fpin.dq_o[7:0])
        8'h01: lb[bi][0] = 1'b1;
        8'hd0: if (!(lb[bi][1] && !f_wp_n)) lb[bi][0] = 1'b0;
        8'h2f: lb[bi] = 2'b11;
        default: sr = sr | 8'hb0;
      endcase
    end else if (pend != 8'h00) begin
      pend = 8'h00;
      mode = 2'd1;
      if (lb[bi][0]) sr = 8'h82;
      else if (vpp_low) sr = 8'h88;
      // Block 2 fails every program and erase, to reach the error flags
      else if (bi == 7'd2)
        sr = (fpin.dq_o[7:0] == 8'hd0) ? 8'ha0 : 8'h90;
      else busy = 3;
    end else begin
      case (fpin.dq_o[7:0])
        8'h60, 8'h40, 8'h20: pend = fpin.dq_o[7:0];
        8'h70: mode = 2'd1;
        8'h90: mode = 2'd2;
        8'hb0: begin
          sr[2] = 1'b1;
          mode = 2'd1;
        end
        8'hd0: sr[2] = 1'b0;
        8'h50: sr = 8'h80;
        default: mode = 2'd0;
      endcase
    end
    wp_q = f_wp_n;
  end
  // ----
  // Read data; slow answer keeps ready low for two status reads
  // ----
  always @(negedge fpin.oe_n) begin
    rsv = ~rsv;
    if (mode == 2'd1 && busy > 0) busy--;
  end
  always_comb begin
    rd = 16'hffff;
    if (mode == 2'd1) rd = {8'h00, sr[7] && busy == 0, sr[6:1], rsv};
    if (mode == 2'd2) rd = (fpin.addr[14:0] == 15'h2) ? {14'h0, lb[bi]} : 16'h0;
  end
  // Released bus shows the inverse of the last word, never a held value
  always @(posedge fpin.oe_n) last = rd;
  assign f_dq_i = (!fpin.ce_n && !fpin.oe_n) ? rd : ~last;
endmodule : blk_flash_model
